// File: pkg/rffim_pkg.sv
/*
   Shared constants and carriers for the receive frame admission filter and
   MAC interrupt mask block. Assumes a byte-wide receive stream and a per-frame
   status word from the receive front end, both on the system clock.
*/
package rffim_pkg;

   // ==========================================================
   // register map (byte addresses on the plain register port)
   localparam logic [7:0]  REG_MASK_SET    = 8'h00;
   localparam logic [7:0]  REG_MASK_CLEAR  = 8'h04;
   localparam logic [7:0]  REG_STAT_RAW    = 8'h08;
   localparam logic [7:0]  REG_STAT_MASKED = 8'h0C;
   localparam logic [7:0]  REG_ADMIT       = 8'h10;
   localparam logic [7:0]  REG_MAC_CONFIG  = 8'h14;
   localparam logic [7:0]  REG_EV_STATUS   = 8'h18;
   localparam logic [7:0]  REG_EV_CLEAR    = 8'h1C;
   localparam logic [7:0]  REG_EV_ENABLE   = 8'h20;
   localparam logic [7:0]  REG_LAST_DESC   = 8'h24;

   // ==========================================================
   // mask registers: bit 1 host error, bit 0 statistics
   localparam int          MASK_HOST_BIT   = 1;
   localparam int          MASK_STAT_BIT   = 0;
   localparam int          MASK_W          = 2;

   // ==========================================================
   // admission enable register fields
   localparam int          ADM_KEEP_FCS    = 30;
   localparam int          ADM_QOS         = 29;
   localparam int          ADM_NOCHAIN     = 28;
   localparam int          ADM_COPY_CTRL   = 24;
   localparam int          ADM_COPY_SHORT  = 23;
   localparam int          ADM_COPY_ERR    = 22;
   localparam int          ADM_COPY_MISS   = 21;
   localparam int          ADM_PROM_LSB    = 16;
   localparam int          ADM_BCAST       = 13;
   localparam int          ADM_BCAST_LSB   = 8;
   localparam int          ADM_MCAST       = 5;
   localparam int          ADM_MCAST_LSB   = 0;
   localparam logic [31:0] ADMIT_RW_MASK   = 32'h71E7_2727;
   localparam logic [31:0] ADMIT_RESET     = 32'h0000_0000;
   localparam int          CFG_PAUSE_BIT   = 3;

   // ==========================================================
   // event status bits
   localparam int          EV_ADMIT        = 0;
   localparam int          EV_FILTER       = 1;
   localparam int          EV_PAUSE        = 2;
   localparam int          EV_TRUNC        = 3;
   localparam int          EV_W            = 4;

   // ==========================================================
   // frame size figures
   localparam logic [15:0] SHORT_LEN       = 16'd64;
   localparam logic [15:0] FCS_BYTES       = 16'd4;
   localparam logic [2:0]  DLY_DEPTH       = 3'd4;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic        valid;
      logic        last;
      logic [7:0]  data;
   } rffim_byte_s;

   typedef struct packed {
      logic        valid;          // one-cycle pulse after the last byte
      logic        is_control;
      logic        is_pause;
      logic        is_broadcast;
      logic        is_multicast;
      logic        hash_match;
      logic        addr_match;
      logic [2:0]  match_channel;
      logic        crc_err;
      logic        align_err;
      logic        code_err;
      logic [15:0] byte_count;     // received bytes including the fcs
   } rffim_frame_s;

   typedef struct packed {
      logic        control;
      logic        errored_runt_flag;
      logic        clean_runt_flag;
      logic        address_miss_flag;
      logic        crc_err;
      logic        align_err;
      logic        code_err;
      logic        truncated;
   } rffim_flags_s;

   typedef struct packed {
      logic         valid;
      logic         admit;
      logic [2:0]   channel;
      rffim_flags_s flags;
      logic [15:0]  packet_len;
      logic [15:0]  buffer_len;
   } rffim_desc_s;

   typedef struct packed {
      logic        valid;
      logic        buf_next;
      logic [7:0]  data;
   } rffim_wr_s;

   typedef struct packed {
      logic        keep_received_fcs;
      logic        rx_qos_enable;
      logic        single_buffer_per_frame;
   } rffim_cfg_s;

endpackage

// File: verilog/rffim_flag_bank.sv
/*
   Small bank of set/clear flags, used for the interrupt masks and for the
   sticky event status. Assumes set and clear vectors are same-clock pulses.
*/
`timescale 1ns/1ps

module rffim_flag_bank #(
   parameter int W = 2
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] set_v,
   input  wire logic [W-1:0] clr_v,
   output logic      [W-1:0] q
);
   import rffim_pkg::*;

   typedef struct packed {
      logic [W-1:0] flags;
   } rffim_bank_s;

   rffim_bank_s st;
   rffim_bank_s next_st;

   // ==========================================================
   // set wins over a clear in the same cycle so no event is lost
   always_comb begin
      next_st       = st;
      next_st.flags = (st.flags & ~clr_v) | set_v;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.flags;

endmodule // rffim_flag_bank

// File: verilog/rffim_filter.sv
/*
   Receive frame admission filter with MAC interrupt mask set/clear, event
   interrupt and byte write path toward the receive DMA.
   Assumes the receive front end delivers bytes and a frame status pulse on
   clk; the status of a frame arrives before the next frame's first byte.
*/
// Design decisions made here: the plain strobed port and the address map.
// Function
// (RL1) writing one to clear bit 1 disables the host error interrupt
// (RL2) writing one to clear bit 0 disables the statistics interrupt
// (RL3) reading clear bits returns current mask state, same as set register
// (RL4) fcs pass bit zero: drop fcs, exclude it from packet length
// (RL5) fcs pass bit one: write fcs to memory, count it in length
// (RL6) bit 29 enables receive quality of service
// (RL7) no-chaining zero: a frame may span several consecutive buffers
// (RL8) no-chaining one: one buffer per frame, excess data dropped
// (RL9) no-chaining: buffer length reports full frame count up to 65535
// (RL10) control copy one: control frames written, control flag set
// (RL11) control copy zero: control frames not written but still processed
// (RL12) pause frames acted on when pause enabled, whatever control copy says
// (RL13) short copy bit: frames under 64 bytes written or filtered
// (RL14) copied short frames flagged errored runt or clean runt
// (RL15) writable fields reset to zero, reserved bits read zero
// (RL16) error copy bit: errored frames written with flags, or filtered
// (RL17) copy-all: address misses go to promiscuous channel, miss flagged
// (RL18) bits 18-16 select the promiscuous channel
// (RL19) broadcast bit: broadcasts to broadcast channel, or filtered
`timescale 1ns/1ps

module rffim_filter (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   // register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wr_data,
   input  wire logic                  reg_wr_en,
   input  wire logic                  reg_rd_en,
   output logic      [31:0]           reg_rd_data,
   // pending sources from the MAC core
   input  wire logic                  host_error_irq_pending,
   input  wire logic                  statistics_irq_pending,
   // receive stream and frame status
   input  wire rffim_pkg::rffim_byte_s  rx_byte,
   input  wire rffim_pkg::rffim_frame_s rx_frame,
   input  wire logic [15:0]           buffer_size,
   // toward the receive DMA
   output rffim_pkg::rffim_wr_s       mem_wr,
   output rffim_pkg::rffim_desc_s     desc,
   output rffim_pkg::rffim_cfg_s      cfg,
   output logic                       pause_act,
   output logic                       mac_irq,
   output logic                       irq
);
   import rffim_pkg::*;

   typedef struct packed {
      logic [31:0]     admit;
      logic            pause_en;
      logic [3:0][7:0] dly;
      logic [2:0]      fill;
      logic [15:0]     buf_cnt;
      logic            drop;
      rffim_wr_s       wr;
      rffim_desc_s     desc;
      rffim_desc_s     last_desc;
      logic            pause_go;
      logic [31:0]     rd_data;
   } rffim_state_s;

   rffim_state_s        st;
   rffim_state_s        next_st;
   logic [MASK_W-1:0]   mask;
   logic [MASK_W-1:0]   mask_set;
   logic [MASK_W-1:0]   mask_clr;
   logic [MASK_W-1:0]   pend;
   logic [EV_W-1:0]     ev_q;
   logic [EV_W-1:0]     ev_set;
   logic [EV_W-1:0]     ev_clr;
   logic [EV_W-1:0]     ev_en;
   logic [EV_W-1:0]     ev_en_set;
   logic [EV_W-1:0]     ev_en_clr;

   // ==========================================================
   // admission fields, decoded from the live register
   logic                keep_fcs;
   logic                nochain;
   logic                copy_ctrl;
   logic                copy_short;
   logic                copy_err;
   logic                copy_miss;
   logic [2:0]          prom_ch;
   logic [2:0]          bcast_ch;
   logic [2:0]          mcast_ch;

   assign keep_fcs   = st.admit[ADM_KEEP_FCS];
   assign nochain    = st.admit[ADM_NOCHAIN];
   assign copy_ctrl  = st.admit[ADM_COPY_CTRL];
   assign copy_short = st.admit[ADM_COPY_SHORT];
   assign copy_err   = st.admit[ADM_COPY_ERR];
   assign copy_miss  = st.admit[ADM_COPY_MISS];
   assign prom_ch    = st.admit[ADM_PROM_LSB +: 3];     // RL18
   assign bcast_ch   = st.admit[ADM_BCAST_LSB +: 3];
   assign mcast_ch   = st.admit[ADM_MCAST_LSB +: 3];
   assign pend       = {host_error_irq_pending, statistics_irq_pending};

   // ==========================================================
   // mask bank: set register enables, clear register disables
   assign mask_set = (reg_wr_en && reg_addr == REG_MASK_SET) ? reg_wr_data[MASK_W-1:0] : '0;
   assign mask_clr = (reg_wr_en && reg_addr == REG_MASK_CLEAR) ?
                     reg_wr_data[MASK_W-1:0] : '0;                 // RL1 RL2

   rffim_flag_bank #(.W(MASK_W)) u_mask (
      .clk    (clk),
      .arst_n (arst_n),
      .set_v  (mask_set),
      .clr_v  (mask_clr),
      .q      (mask)
   );

   // ==========================================================
   // event interrupt: sticky status, write-only clear, enable
   assign ev_clr    = (reg_wr_en && reg_addr == REG_EV_CLEAR) ? reg_wr_data[EV_W-1:0] : '0;
   assign ev_en_set = (reg_wr_en && reg_addr == REG_EV_ENABLE) ? reg_wr_data[EV_W-1:0] : '0;
   assign ev_en_clr = (reg_wr_en && reg_addr == REG_EV_ENABLE) ? ~reg_wr_data[EV_W-1:0] : '0;

   rffim_flag_bank #(.W(EV_W)) u_ev_status (
      .clk    (clk),
      .arst_n (arst_n),
      .set_v  (ev_set),
      .clr_v  (ev_clr),
      .q      (ev_q)
   );

   // enable is plain read/write, reused bank with set and clear from one word
   rffim_flag_bank #(.W(EV_W)) u_ev_enable (
      .clk    (clk),
      .arst_n (arst_n),
      .set_v  (ev_en_set),
      .clr_v  (ev_en_clr),
      .q      (ev_en)
   );

   // ==========================================================
   // next-state: register access, byte path, frame decision
   always_comb begin
      logic          byte_ok;
      logic [7:0]    byte_out;
      logic          short_f;
      logic          err_f;
      logic          ok;
      logic          miss;
      logic [2:0]    ch;
      rffim_desc_s   d;
      byte_ok          = 1'b0;
      byte_out         = '0;
      short_f          = 1'b0;
      err_f            = 1'b0;
      ok               = 1'b0;
      miss             = 1'b0;
      ch               = '0;
      d                = '0;
      next_st          = st;
      next_st.wr       = '0;
      next_st.desc     = '0;
      next_st.pause_go = 1'b0;
      next_st.rd_data  = '0;
      ev_set           = '0;

      // register writes; reserved bits never stored
      if (reg_wr_en) begin
         case (reg_addr)
            REG_ADMIT:      next_st.admit    = reg_wr_data & ADMIT_RW_MASK;  // RL15
            REG_MAC_CONFIG: next_st.pause_en = reg_wr_data[CFG_PAUSE_BIT];
            default:        ;
         endcase
      end

      // reads answer one cycle later, unmapped reads give zero
      if (reg_rd_en) begin
         case (reg_addr)
            REG_MASK_SET,
            REG_MASK_CLEAR:  next_st.rd_data = {30'h0, mask}; // RL3
            REG_STAT_RAW:    next_st.rd_data = {30'h0, pend};
            REG_STAT_MASKED: next_st.rd_data = {30'h0, pend & mask};
            REG_ADMIT:       next_st.rd_data = st.admit; // RL15
            REG_MAC_CONFIG:  next_st.rd_data = {28'h0, st.pause_en, 3'h0};
            REG_EV_STATUS:   next_st.rd_data = {28'h0, ev_q};
            REG_EV_ENABLE:   next_st.rd_data = {28'h0, ev_en};
            REG_LAST_DESC:   next_st.rd_data = {st.last_desc.packet_len,
                                                st.last_desc.flags,
                                                3'h0, st.last_desc.admit,
                                                1'b0, st.last_desc.channel};
            default:         next_st.rd_data = '0;
         endcase
      end

      // byte path; the fcs is held back in a four-byte delay line when dropped
      if (rx_byte.valid) begin
         if (keep_fcs) begin
            byte_ok  = 1'b1; // RL5
            byte_out = rx_byte.data;
         end else begin
            byte_ok  = (st.fill == DLY_DEPTH); // RL4
            byte_out = st.dly[3];
            next_st.dly = {st.dly[2:0], rx_byte.data};
            if (st.fill != DLY_DEPTH) begin
               next_st.fill = st.fill + 3'd1;
            end
         end
         if (st.drop) begin
            byte_ok = 1'b0;
         end else if (byte_ok) begin
            if (st.buf_cnt == buffer_size) begin
               if (nochain) begin
                  byte_ok      = 1'b0; // RL8
                  next_st.drop = 1'b1;
               end else begin
                  next_st.wr.buf_next = 1'b1; // RL7
                  next_st.buf_cnt     = 16'd1;
               end
            end else begin
               next_st.buf_cnt = st.buf_cnt + 16'd1;
            end
         end
         next_st.wr.valid = byte_ok;
         next_st.wr.data  = byte_out;
         // the held fcs bytes are simply never released
         if (rx_byte.last) begin
            next_st.fill    = '0;
            next_st.buf_cnt = '0;
         end
      end

      // frame decision at the status pulse
      if (rx_frame.valid) begin
         short_f = rx_frame.byte_count < SHORT_LEN;
         err_f   = rx_frame.crc_err | rx_frame.align_err | rx_frame.code_err;
         // address stage
         if (rx_frame.is_broadcast) begin
            ok = st.admit[ADM_BCAST]; // RL19
            ch = bcast_ch;
         end else if (rx_frame.is_multicast && rx_frame.hash_match) begin
            ok = st.admit[ADM_MCAST];
            ch = mcast_ch;
         end else if (rx_frame.addr_match && !rx_frame.is_multicast) begin
            ok = 1'b1;
            ch = rx_frame.match_channel;
         end else begin
            ok   = copy_miss; // RL17
            miss = 1'b1;
            ch   = prom_ch; // RL18
         end
         // content stage
         if (rx_frame.is_control && !copy_ctrl) begin
            ok = 1'b0; // RL11
         end
         if (short_f && !copy_short) begin
            ok = 1'b0; // RL13
         end
         if (err_f && !short_f && !copy_err) begin
            ok = 1'b0; // RL16
         end
         d.valid                   = 1'b1;
         d.admit                   = ok;
         d.channel                 = ch;
         d.flags.control           = rx_frame.is_control; // RL10
         d.flags.errored_runt_flag = short_f & err_f; // RL14
         d.flags.clean_runt_flag   = short_f & ~err_f; // RL14
         d.flags.address_miss_flag = miss; // RL17
         d.flags.crc_err           = rx_frame.crc_err; // RL16
         d.flags.align_err         = rx_frame.align_err;
         d.flags.code_err          = rx_frame.code_err;
         d.flags.truncated         = st.drop;
         if (keep_fcs || rx_frame.byte_count < FCS_BYTES) begin
            d.packet_len = rx_frame.byte_count; // RL5
         end else begin
            d.packet_len = rx_frame.byte_count - FCS_BYTES; // RL4
         end
         // single-buffer mode reports the whole frame, not what fitted
         d.buffer_len = nochain ? d.packet_len : // RL9
                        ((d.packet_len > buffer_size) ? buffer_size : d.packet_len);
         next_st.desc      = d;
         next_st.last_desc = d;
         next_st.drop      = 1'b0;
         // pause is acted on even when the frame itself is filtered
         next_st.pause_go  = rx_frame.is_pause & st.pause_en;                // RL12
         ev_set[EV_ADMIT]  = ok;
         ev_set[EV_FILTER] = ~ok;
         ev_set[EV_PAUSE]  = rx_frame.is_pause & st.pause_en;
         ev_set[EV_TRUNC]  = st.drop;
      end
   end

   // ==========================================================
   // single state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st       <= '0;
         st.admit <= ADMIT_RESET;                                            // RL15
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs
   assign reg_rd_data                 = st.rd_data;
   assign mem_wr                      = st.wr;
   assign desc                        = st.desc;
   assign pause_act                   = st.pause_go;
   assign cfg.keep_received_fcs       = keep_fcs;
   assign cfg.rx_qos_enable           = st.admit[ADM_QOS];                   // RL6
   assign cfg.single_buffer_per_frame = nochain;
   assign mac_irq                     = |(pend & mask);                      // RL1 RL2
   assign irq                         = |(ev_q & ev_en);

endmodule // rffim_filter

// File: tb/rffim_filter_assertions.sv
/*
   Port checker for rffim_filter, bound to every instance below.
   Assumes the register map and field positions of rffim_pkg.
*/
`timescale 1ns/1ps

module rffim_filter_chk (
   input wire logic                    clk,
   input wire logic                    arst_n,
   input wire logic [7:0]              reg_addr,
   input wire logic [31:0]             reg_wr_data,
   input wire logic                    reg_wr_en,
   input wire logic                    reg_rd_en,
   input wire logic [31:0]             reg_rd_data,
   input wire logic                    host_error_irq_pending,
   input wire logic                    statistics_irq_pending,
   input wire rffim_pkg::rffim_byte_s  rx_byte,
   input wire rffim_pkg::rffim_frame_s rx_frame,
   input wire logic [15:0]             buffer_size,
   input wire rffim_pkg::rffim_wr_s    mem_wr,
   input wire rffim_pkg::rffim_desc_s  desc,
   input wire rffim_pkg::rffim_cfg_s   cfg,
   input wire logic                    pause_act,
   input wire logic                    mac_irq,
   input wire logic                    irq
);
   import rffim_pkg::*;

   // ==========================================================
   // shadow of mask and pause enable, built from writes alone
   logic [1:0] mask_m;
   logic       pause_en;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_m   <= 2'h0;
         pause_en <= 1'b0;
      end else if (reg_wr_en) begin
         if (reg_addr == REG_MASK_SET)
            mask_m <= mask_m | reg_wr_data[1:0];
         else if (reg_addr == REG_MASK_CLEAR)
            mask_m <= mask_m & ~reg_wr_data[1:0];
         else if (reg_addr == REG_MAC_CONFIG)
            pause_en <= reg_wr_data[CFG_PAUSE_BIT];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // ==========================================================
   // assertions
   mask_irq_a: assert property (
      mac_irq == |({host_error_irq_pending, statistics_irq_pending} & mask_m))
      else $error("mac_irq wrong");
   clr_read_a: assert property (
      reg_rd_en && reg_addr == REG_MASK_CLEAR |=> reg_rd_data == {30'h0, $past(mask_m)})
      else $error("mask read wrong");
   adm_rsvd_a: assert property (
      reg_rd_en && reg_addr == REG_ADMIT |=> (reg_rd_data & ~ADMIT_RW_MASK) == 32'h0)
      else $error("reserved bits set");
   cfg_follow_a: assert property (
      reg_wr_en && reg_addr == REG_ADMIT |=> cfg == $past(reg_wr_data[30:28]))
      else $error("cfg wrong");
   desc_time_a: assert property (
      desc.valid == $past(rx_frame.valid))
      else $error("descriptor late");
   fcs_len_a: assert property (
      rx_frame.valid && rx_frame.byte_count >= 16'h4 |=> desc.packet_len ==
      ($past(cfg.keep_received_fcs) ? $past(rx_frame.byte_count)
                                     : $past(rx_frame.byte_count) - FCS_BYTES))
      else $error("packet length wrong");
   pause_act_a: assert property (
      pause_act == $past(rx_frame.valid && rx_frame.is_pause && pause_en))
      else $error("pause action wrong");
   fcs_pass_a: assert property (
      rx_byte.valid && cfg.keep_received_fcs && !cfg.single_buffer_per_frame
      |=> mem_wr.valid && mem_wr.data == $past(rx_byte.data))
      else $error("kept byte lost");
   nochain_len_a: assert property (
      rx_frame.valid && rx_frame.byte_count >= 16'h4 && cfg.single_buffer_per_frame
      |=> desc.buffer_len == $past(rx_frame.byte_count) -
          ($past(cfg.keep_received_fcs) ? 16'h0 : FCS_BYTES))
      else $error("buffer length wrong");

   pause_c: cover property (pause_act);
   chain_c: cover property (mem_wr.valid && mem_wr.buf_next);
   trunc_c: cover property (desc.valid && desc.flags.truncated);
endmodule // rffim_filter_chk

bind rffim_filter rffim_filter_chk u_chk (.*);

// File: tb/rffim_phy_model.sv
/*
   Behavioural receive PHY: one frame of counted bytes, then its status.
   Assumes send is entered right after a rising edge of clk.
*/
`timescale 1ns/1ps

module rffim_phy_model (
   input  wire logic               clk,
   output rffim_pkg::rffim_byte_s  rx_byte,
   output rffim_pkg::rffim_frame_s rx_frame
);
   import rffim_pkg::*;

   initial begin
      rx_byte  = '0;
      rx_frame = '0;
   end

   // ==========================================================
   // a slow sender leaves an idle cycle after each byte
   task automatic send(input rffim_frame_s f, input logic slow);
      for (int i = 0; i < int'(f.byte_count); i++) begin
         rx_byte <= '{1'b1, i == int'(f.byte_count) - 1, 8'(i) ^ 8'hA5};
         @(posedge clk);
         if (slow) begin
            rx_byte <= '{1'b0, 1'b0, ~rx_byte.data};
            @(posedge clk);
         end
      end
      // released lines show the inverse so a stale value cannot pass
      rx_byte  <= '{1'b0, 1'b0, ~rx_byte.data};
      rx_frame <= f;
      @(posedge clk);
      rx_frame <= {1'b0, ~f[27:0]};
   endtask
endmodule // rffim_phy_model

// File: tb/rffim_filter_test.sv
/*
   Self-checking bench for rffim_filter: register tasks and frame scenarios.
   Assumes the PHY model and the bound checker.
*/
`timescale 1ns/1ps

module rffim_filter_test;
   import rffim_pkg::*;

   logic         clk = 1'b0;
   logic         arst_n = 1'b0;
   logic [7:0]   reg_addr = 8'h00;
   logic [31:0]  reg_wr_data = 32'h0;
   logic         reg_wr_en = 1'b0;
   logic         reg_rd_en = 1'b0;
   logic [31:0]  reg_rd_data;
   logic         host_error_irq_pending = 1'b0;
   logic         statistics_irq_pending = 1'b0;
   logic [15:0]  buffer_size = 16'h0600;
   rffim_byte_s  rx_byte;
   rffim_frame_s rx_frame;
   rffim_wr_s    mem_wr;
   rffim_desc_s  desc, dq;
   rffim_cfg_s   cfg;
   logic         pause_act, mac_irq, irq;
   int           n_errors = 0, checked = 0, cyc = 0, nw, nb, np;

   rffim_filter u_dut (.*);
   rffim_phy_model u_phy (.clk(clk), .rx_byte(rx_byte), .rx_frame(rx_frame));

   always #5 clk = ~clk;

   // ==========================================================
   // monitor counts and timeout
   always @(posedge clk) begin
      nw += int'(mem_wr.valid);
      nb += int'(mem_wr.valid && mem_wr.buf_next);
      np += int'(pause_act);
      if (desc.valid) dq = desc;
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      checked++;
      if (got !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask

   // strobe dropped, one idle cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr    <= a;
      reg_wr_data <= d;
      reg_wr_en   <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      reg_addr  <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      #1 chk(reg_rd_data, e);
      @(posedge clk);
   endtask

   // k: bit4 broadcast, bit3 miss, bit2 control, bit1 pause, bit0 crc error
   task automatic ft(input logic [31:0] adm, input logic [15:0] n,
                     input logic [4:0] k, input logic slow);
      rffim_frame_s f;
      wr(REG_ADMIT, adm);
      f = '0;
      f.valid = 1'b1;
      f.byte_count = n;
      {f.is_control, f.is_pause, f.crc_err} = k[2:0];
      f.addr_match = !k[3];
      f.is_broadcast = k[4];
      dq = '1;
      nw = 0;
      nb = 0;
      np = 0;
      u_phy.send(f, slow);
      repeat (3) @(posedge clk);
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rc(REG_MASK_SET, 32'h0);
      rc(REG_ADMIT, 32'h0);
      rc(8'hFC, 32'h0);
      host_error_irq_pending <= 1'b1;
      statistics_irq_pending <= 1'b1;
      wr(REG_MASK_SET, 32'h3);
      wr(REG_MASK_CLEAR, 32'h0);
      rc(REG_MASK_CLEAR, 32'h3);
      wr(REG_MASK_CLEAR, 32'h2);
      rc(REG_MASK_CLEAR, 32'h1);
      chk(mac_irq, 1'b1);
      wr(REG_MASK_CLEAR, 32'h1);
      rc(REG_MASK_SET, 32'h0);
      chk(mac_irq, 1'b0);
      wr(REG_ADMIT, 32'hFFFF_FFFF);
      rc(REG_ADMIT, ADMIT_RW_MASK);
      chk(cfg, 3'h7);
      $display("test registers done");
      // fcs dropped, then kept with a slow sender
      ft(32'h0, 16'd68, 4'h0, 1'b0);
      chk(dq.admit, 1'b1);
      chk(dq.packet_len, 16'd64);
      chk(nw, 64);
      ft(32'h4000_0000, 16'd68, 4'h0, 1'b1);
      chk(dq.packet_len, 16'd68);
      chk(nw, 68);
      // short frames filtered, then copied clean and errored
      ft(32'h0, 16'd40, 4'h0, 1'b0);
      chk(dq.admit, 1'b0);
      ft(32'h0080_0000, 16'd40, 4'h0, 1'b0);
      chk(dq.admit, 1'b1);
      chk(dq.flags.clean_runt_flag, 1'b1);
      ft(32'h0080_0000, 16'd40, 4'h1, 1'b0);
      chk(dq.flags.errored_runt_flag, 1'b1);
      chk(dq.flags.clean_runt_flag, 1'b0);
      // control frames, then a pause frame with pause handling on
      ft(32'h0, 16'd68, 4'h4, 1'b0);
      chk(dq.admit, 1'b0);
      ft(32'h0100_0000, 16'd68, 4'h4, 1'b0);
      chk(dq.admit, 1'b1);
      chk(dq.flags.control, 1'b1);
      wr(REG_MAC_CONFIG, 32'h0000_0008);
      ft(32'h0, 16'd68, 4'h6, 1'b0);
      chk(dq.admit, 1'b0);
      chk(np, 1);
      // address miss filtered, then sent to promiscuous channel 5
      ft(32'h0, 16'd68, 4'h8, 1'b0);
      chk(dq.admit, 1'b0);
      ft(32'h0025_0000, 16'd68, 4'h8, 1'b0);
      chk(dq.flags.address_miss_flag, 1'b1);
      chk(dq.channel, 3'h5);
      ft(32'h0040_0000, 16'd68, 5'h01, 1'b0);
      chk(dq.flags.crc_err, 1'b1);
      ft(32'h0, 16'd68, 5'h01, 1'b0);
      chk(dq.admit, 1'b0);
      ft(32'h0000_2300, 16'd68, 5'h10, 1'b0);
      chk(dq.admit, 1'b1);
      chk(dq.channel, 3'h3);
      // small buffers: single buffer truncates, chaining spans three
      buffer_size <= 16'd16;
      ft(32'h5000_0000, 16'd68, 4'h0, 1'b0);
      chk(dq.buffer_len, 16'd68);
      chk(dq.flags.truncated, 1'b1);
      chk(nw, 16);
      ft(32'h4000_0000, 16'd40, 4'h0, 1'b0);
      chk(nw, 40);
      chk(nb, 2);
      buffer_size <= 16'h0600;
      $display("test frames done");
      wr(REG_EV_CLEAR, 32'hF);
      wr(REG_EV_ENABLE, 32'h1);
      ft(32'h0, 16'd68, 4'h0, 1'b0);
      chk(irq, 1'b1);
      rc(REG_EV_STATUS, 32'h1);
      wr(REG_EV_ENABLE, 32'h0);
      chk(irq, 1'b0);
      wr(REG_EV_ENABLE, 32'h1);
      wr(REG_EV_CLEAR, 32'h1);
      chk(irq, 1'b0);
      rc(REG_EV_STATUS, 32'h0);
      $display("test events done");
      summarize();
   end
endmodule // rffim_filter_test
